// >>> rtl/monitor_adc_control.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Control and result registers of the monitoring converter
// Assumes: Serial bus slave delivers byte reads and writes on regBus
// Notes:   Read data appears one clock after the address is presented
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps

// Summary of operation
// RULE1: Conversions start only while enable bit 7 is set; reg and watchdog reset clear it.
// RULE2: Rate bit 6 clear converts continuously; set runs one single pass.
// RULE3: Resolution field bits 5:4 picks 15, 14, 13 or 12 bits; resets to 11.
// RULE4: Converter control register holds 0x30 after reset.
// RULE5: Reserved control bits 3:0 and channel bit 1 always read zero.
// RULE6: Each channel disable bit skips its channel; positions 7 down to 0 except 1.
// RULE7: Channel disable register resets to 0x00, every channel converted.
// RULE8: Input current result is 16-bit two's complement, bit 15 sign.
// RULE9: Positive current flows into bus supply pin, 1 mA per LSB.
// RULE10: Register 0x17 shows input current bits 15:8.
// RULE11: Register 0x18 shows input current bits 7:0.
// RULE12: Register 0x19 shows charge current bits 14:8, bit 7 reads zero.
// RULE13: Results reset to zero by register reset, not by watchdog expiry.
// RULE14: One-shot completion pulses the done event unless masked.
// RULE15: Register 0x1A shows charge current bits 7:0.
// RULE16: One-shot pass end clears the enable bit after results stored.
// RULE17: High and low result bytes update together in one cycle.
module monitor_adc_control (
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   // Device level resets
   input  wire logic                      regReset,
   input  wire logic                      watchdogExpire,
   // Host register access
   input  wire adc_ctrl_pkg::reg_access_t regBus,
   output logic [7:0]                     rdData,
   // Analog converter
   output adc_ctrl_pkg::conv_req_t        convReq,
   input  wire adc_ctrl_pkg::conv_rsp_t   convRsp,
   // Done event to interrupt logic
   input  wire logic                      doneMask,
   output logic                           doneEvent
);

   // Whole block state in one register; outputs are read straight from it
   adc_ctrl_pkg::core_t q_reg;
   adc_ctrl_pkg::core_t q_next;

   logic       pickFound;
   logic [2:0] pickIdx;
   logic       enabled;
   logic       oneShot;
   logic       seqIdle;
   logic       convFinished;
   logic       passEnd;

   assign enabled = q_reg.control[adc_ctrl_pkg::ENABLE_BIT];
   assign oneShot = q_reg.control[adc_ctrl_pkg::RATE_BIT];

   // Sequencer status shared by the picker and the next-state logic
   assign seqIdle      = (q_reg.state == adc_ctrl_pkg::ST_IDLE);
   assign convFinished = (q_reg.state == adc_ctrl_pkg::ST_WAIT) && convRsp.done;
   // Pass ends once no enabled channel is left below the one just converted
   assign passEnd      = convFinished && !(pickFound && enabled);

   // Picker searches from the top when idle, below the current channel in a pass
   channel_picker u_picker (
      .channelOff (q_reg.channelOff),
      .currentIdx (q_reg.channel),
      .fromTop    (seqIdle),
      .found      (pickFound),
      .nextIdx    (pickIdx)
   );

   //////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      q_next           = q_reg;
      q_next.start     = 1'b0;
      q_next.doneEvent = 1'b0;

      // Register read path
      // Address is sampled on every edge, so read data trails it by one clock
      case (regBus.addr)
         adc_ctrl_pkg::ADDR_CONVERTER_CONTROL: begin
            // RULE5 reserved read zero
            q_next.rdData = q_reg.control & adc_ctrl_pkg::CONTROL_WRMASK;
         end
         adc_ctrl_pkg::ADDR_CHANNEL_DISABLE: begin
            q_next.rdData = q_reg.channelOff & adc_ctrl_pkg::CHANNEL_VALID;
         end
         adc_ctrl_pkg::ADDR_INPUT_CURRENT_HIGH: begin
            // RULE10 high byte
            q_next.rdData = q_reg.inputCurrent[15:8];
         end
         adc_ctrl_pkg::ADDR_INPUT_CURRENT_LOW: begin
            // RULE11 low byte
            q_next.rdData = q_reg.inputCurrent[7:0];
         end
         adc_ctrl_pkg::ADDR_CHARGE_CURRENT_HIGH: begin
            // RULE12 bit 7 zero
            q_next.rdData = {1'b0, q_reg.chargeCurrent[14:8]};
         end
         adc_ctrl_pkg::ADDR_CHARGE_CURRENT_LOW: begin
            // RULE15 low byte
            q_next.rdData = q_reg.chargeCurrent[7:0];
         end
         default: begin
            q_next.rdData = adc_ctrl_pkg::READ_ZERO;
         end
      endcase

      // Conversion sequencer
      case (q_reg.state)
         adc_ctrl_pkg::ST_IDLE: begin
            // RULE1 start gated by enable
            if (enabled) begin
               if (pickFound) begin
                  q_next.channel = pickIdx;
                  q_next.start   = 1'b1;
                  q_next.state   = adc_ctrl_pkg::ST_WAIT;
               end else if (oneShot) begin
                  // RULE16 empty pass ends
                  q_next.control[adc_ctrl_pkg::ENABLE_BIT] = 1'b0;
                  q_next.doneEvent = ~doneMask;
               end
            end
         end
         adc_ctrl_pkg::ST_WAIT: begin
            // Done is only taken while a started conversion is pending
            if (convFinished) begin
               // RULE17 whole word stored
               // Both bytes change on one edge, never half of an old word
               if (q_reg.channel == adc_ctrl_pkg::CH_INPUT_CURRENT) begin
                  // RULE8 signed word kept
                  // RULE9 sign from converter
                  q_next.inputCurrent = convRsp.data;
               end
               if (q_reg.channel == adc_ctrl_pkg::CH_CHARGE_CURRENT) begin
                  q_next.chargeCurrent = convRsp.data[14:0];
               end
               // RULE2 continue or end pass
               if (!passEnd) begin
                  q_next.channel = pickIdx;
                  q_next.start   = 1'b1;
               end else begin
                  q_next.state = adc_ctrl_pkg::ST_IDLE;
                  if (oneShot && enabled) begin
                     // RULE16 clear enable
                     q_next.control[adc_ctrl_pkg::ENABLE_BIT] = 1'b0;
                     // RULE14 done pulse
                     q_next.doneEvent = ~doneMask;
                  end
               end
            end
         end
         default: begin
            q_next.state = adc_ctrl_pkg::ST_IDLE;
         end
      endcase

      // Host writes win over hardware clear
      // so a rewrite of enable in the one-shot end cycle starts a new pass
      if (regBus.wrEn) begin
         case (regBus.addr)
            adc_ctrl_pkg::ADDR_CONVERTER_CONTROL: begin
               // RULE3 resolution field
               q_next.control = regBus.wrData & adc_ctrl_pkg::CONTROL_WRMASK;
            end
            adc_ctrl_pkg::ADDR_CHANNEL_DISABLE: begin
               // RULE6 channel bits
               q_next.channelOff = regBus.wrData & adc_ctrl_pkg::CHANNEL_VALID;
            end
            default: begin
               q_next.channelOff = q_next.channelOff;
            end
         endcase
      end

      // RULE1 watchdog clears enable
      // RULE13 results kept
      // Applied after the host write, so it stops the converter regardless
      if (watchdogExpire) begin
         q_next.control[adc_ctrl_pkg::ENABLE_BIT] = 1'b0;
      end

      // RULE1 start needs enable
      // A start planned as enable drops would launch a conversion
      // that the host or the watchdog has just switched off
      if (q_next.start && !q_next.control[adc_ctrl_pkg::ENABLE_BIT]) begin
         q_next.start   = 1'b0;
         q_next.state   = adc_ctrl_pkg::ST_IDLE;
         q_next.channel = q_reg.channel;
      end

      // Register reset acts last, so nothing set above survives it
      // RULE4 control reset
      // RULE7 channel reset
      // RULE13 results cleared
      if (regReset) begin
         q_next = adc_ctrl_pkg::CORE_RESET;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // State register
   // Synchronous reset loads constants only
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q_reg <= adc_ctrl_pkg::CORE_RESET;
      end else begin
         q_reg <= q_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Outputs
   assign rdData             = q_reg.rdData;
   assign doneEvent          = q_reg.doneEvent;
   assign convReq.start      = q_reg.start;
   assign convReq.channel    = q_reg.channel;
   // RULE3 resolution to converter
   assign convReq.resolution = q_reg.control[adc_ctrl_pkg::RES_HI_BIT:adc_ctrl_pkg::RES_LO_BIT];

endmodule : monitor_adc_control

// >>> rtl/adc_ctrl_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and carriers for the monitor converter control
// Assumes: Byte-wide register port behind the serial control bus slave
// Notes:   Channel index equals its bit position in the channel_disable reg
//////////////////////////////////////////////////////////////////////////////
package adc_ctrl_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_CONVERTER_CONTROL   = 8'h15;
   localparam logic [7:0] ADDR_CHANNEL_DISABLE     = 8'h16;
   localparam logic [7:0] ADDR_INPUT_CURRENT_HIGH  = 8'h17;
   localparam logic [7:0] ADDR_INPUT_CURRENT_LOW   = 8'h18;
   localparam logic [7:0] ADDR_CHARGE_CURRENT_HIGH = 8'h19;
   localparam logic [7:0] ADDR_CHARGE_CURRENT_LOW  = 8'h1a;

   // Reset values and writable masks
   localparam logic [7:0] CONTROL_RESET    = 8'h30;
   localparam logic [7:0] CHANNEL_RESET    = 8'h00;
   localparam logic [7:0] CONTROL_WRMASK   = 8'hf0;
   localparam logic [7:0] CHANNEL_VALID    = 8'hfd;
   localparam logic [7:0] READ_ZERO        = 8'h00;

   // Field positions in converter_control
   localparam int ENABLE_BIT   = 7;
   localparam int RATE_BIT     = 6;
   localparam int RES_HI_BIT   = 5;
   localparam int RES_LO_BIT   = 4;

   // Resolution codes
   localparam logic [1:0] RES_15BIT = 2'h0;
   localparam logic [1:0] RES_14BIT = 2'h1;
   localparam logic [1:0] RES_13BIT = 2'h2;
   localparam logic [1:0] RES_12BIT = 2'h3;

   // Channel indices (bit positions in channel_disable)
   localparam logic [2:0] CH_INPUT_CURRENT  = 3'h7;
   localparam logic [2:0] CH_CHARGE_CURRENT = 3'h6;
   localparam logic [2:0] CH_BUS_VOLTAGE    = 3'h5;
   localparam logic [2:0] CH_BATT_VOLTAGE   = 3'h4;
   localparam logic [2:0] CH_SYS_VOLTAGE    = 3'h3;
   localparam logic [2:0] CH_THERMISTOR     = 3'h2;
   localparam logic [2:0] CH_DIE_TEMP       = 3'h0;
   localparam int         NUM_CHANNELS      = 8;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01
   } seq_state_t;

   // Host register access, one byte per cycle
   typedef struct packed {
      logic       wrEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } reg_access_t;

   // Request to the analog converter
   typedef struct packed {
      logic       start;
      logic [2:0] channel;
      logic [1:0] resolution;
   } conv_req_t;

   // Answer from the analog converter
   typedef struct packed {
      logic        done;
      logic [15:0] data;
   } conv_rsp_t;

   // Whole state of the control block
   typedef struct packed {
      seq_state_t  state;
      logic [7:0]  control;
      logic [7:0]  channelOff;
      logic [15:0] inputCurrent;
      logic [14:0] chargeCurrent;
      logic [2:0]  channel;
      logic        start;
      logic        doneEvent;
      logic [7:0]  rdData;
   } core_t;

   localparam core_t CORE_RESET = '{
      state:         ST_IDLE,
      control:       CONTROL_RESET,
      channelOff:    CHANNEL_RESET,
      inputCurrent:  16'h0000,
      chargeCurrent: 15'h0000,
      channel:       3'h0,
      start:         1'b0,
      doneEvent:     1'b0,
      rdData:        8'h00
   };

endpackage : adc_ctrl_pkg

// >>> rtl/channel_picker.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Finds the next channel to convert, highest index first
// Assumes: Reserved channel positions never selected
// Notes:   Purely combinational
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module channel_picker (
   // Channel selection inputs
   input  wire logic [7:0] channelOff,
   input  wire logic [2:0] currentIdx,
   input  wire logic       fromTop,
   // Result
   output logic            found,
   output logic [2:0]      nextIdx
);

   logic [7:0] candidate;

   // RULE6 skip disabled
   for (genvar i = 0; i < adc_ctrl_pkg::NUM_CHANNELS; i++) begin : g_cand
      assign candidate[i] = ~channelOff[i] & adc_ctrl_pkg::CHANNEL_VALID[i]
                            & (fromTop | (3'(i) < currentIdx));
   end

   always_comb begin
      found   = 1'b0;
      nextIdx = 3'h0;
      for (int i = 0; i < adc_ctrl_pkg::NUM_CHANNELS; i++) begin
         if (candidate[i]) begin
            found   = 1'b1;
            nextIdx = 3'(i);
         end
      end
   end

endmodule : channel_picker

// >>> testbench/monitor_adc_control_chk.sv
// Purpose: Port level checks of the monitor converter control
// Assumes: Sees only the top module ports
// Notes:   Bound to every instance of the top module
`timescale 1ns/10ps
module monitor_adc_control_chk (
   // Clock and resets
   input wire logic                      ref_clk,
   input wire logic                      rst_n,
   input wire logic                      regReset,
   input wire logic                      watchdogExpire,
   // Register and converter side
   input wire adc_ctrl_pkg::reg_access_t regBus,
   input wire logic [7:0]                rdData,
   input wire adc_ctrl_pkg::conv_req_t   convReq,
   input wire adc_ctrl_pkg::conv_rsp_t   convRsp,
   input wire logic                      doneMask,
   input wire logic                      doneEvent
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_CTRL_RESV: assert property (regBus.addr == 8'h15 |=> rdData[3:0] == 4'h0)
      else $error("control reserved bits not zero");
   AST_CHAN_RESV: assert property (regBus.addr == 8'h16 |=> !rdData[1])
      else $error("channel reserved bit not zero");
   AST_CHG_BIT7: assert property (regBus.addr == 8'h19 |=> !rdData[7])
      else $error("charge high byte bit 7 not zero");
   AST_RES_FIELD: assert property (regBus.wrEn && regBus.addr == 8'h15 && !regReset
      |=> convReq.resolution == $past(regBus.wrData[5:4]))
      else $error("resolution does not follow control write");
   AST_REG_RESET: assert property (regReset |=> rdData == 8'h00 && !doneEvent
      && !convReq.start && convReq.resolution == 2'h3)
      else $error("register reset state wrong");
   AST_WDOG_STOP: assert property (watchdogExpire |=> !convReq.start)
      else $error("conversion started as watchdog expired");
   AST_START_PULSE: assert property (convReq.start |=> !convReq.start)
      else $error("start longer than one cycle");
   AST_EVENT_PULSE: assert property (doneEvent |=> !doneEvent)
      else $error("done event longer than one cycle");
   AST_EVENT_MASK: assert property (doneEvent |-> !$past(doneMask))
      else $error("done event while masked");
   AST_NO_CH1: assert property (convReq.start |-> convReq.channel != 3'h1)
      else $error("reserved channel started");
endmodule : monitor_adc_control_chk

bind monitor_adc_control monitor_adc_control_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .regReset(regReset), .watchdogExpire(watchdogExpire), .regBus(regBus), .rdData(rdData),
   .convReq(convReq), .convRsp(convRsp), .doneMask(doneMask), .doneEvent(doneEvent));

// >>> testbench/converter_model.sv
// Purpose: Behavioural analog converter answering start pulses
// Assumes: One conversion at a time
// Notes:   Result depends only on channel; idle data toggles every cycle
`timescale 1ns/10ps
module converter_model (
   // Clock and control
   input wire logic                    ref_clk,
   input wire logic                    slow,
   // Converter link
   input wire adc_ctrl_pkg::conv_req_t convReq,
   output adc_ctrl_pkg::conv_rsp_t     convRsp
);
   logic       busy = 1'b0;
   logic [3:0] waitCnt = 4'h0;
   logic [2:0] ch = 3'h0;

   initial convRsp = '0;
   always @(posedge ref_clk) begin
      convRsp.done <= 1'b0;
      convRsp.data <= ~convRsp.data;
      if (busy) begin
         if (waitCnt == 4'h0) begin
            busy <= 1'b0;
            convRsp.done <= 1'b1;
            convRsp.data <= 16'h8a5c ^ {13'h0000, ch};
         end else begin
            waitCnt <= waitCnt - 4'h1;
         end
      end else if (convReq.start === 1'b1) begin
         busy <= 1'b1;
         ch <= convReq.channel;
         waitCnt <= slow ? 4'h9 : 4'h0;
      end
   end
endmodule : converter_model

// >>> testbench/monitor_adc_control_bench.sv
// Purpose: Register level test of the monitor converter control
// Assumes: Byte register port, read data one cycle after the address
// Notes:   Channel n returns 8a5c xor n from the converter model
`timescale 1ns/10ps
module monitor_adc_control_bench;
   logic                      ref_clk = 1'b0;
   logic                      rst_n = 1'b0;
   logic                      regReset = 1'b0;
   logic                      watchdogExpire = 1'b0;
   logic                      doneMask = 1'b0;
   logic                      slow = 1'b0;
   adc_ctrl_pkg::reg_access_t regBus = '0;
   adc_ctrl_pkg::conv_req_t   convReq;
   adc_ctrl_pkg::conv_rsp_t   convRsp;
   logic [7:0]                rdData;
   logic                      doneEvent;
   logic [2:0]                chans[$];
   logic [7:0]                v;
   int                        evCnt = 0;
   int                        errors = 0;
   int                        compares = 0;
   logic [2:0]                order[7] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h0};

   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (convReq.start === 1'b1) chans.push_back(convReq.channel);
      if (doneEvent === 1'b1) evCnt++;
   end

   monitor_adc_control u_monitor_adc_control (.ref_clk(ref_clk), .rst_n(rst_n),
      .regReset(regReset), .watchdogExpire(watchdogExpire), .regBus(regBus),
      .rdData(rdData), .convReq(convReq), .convRsp(convRsp), .doneMask(doneMask),
      .doneEvent(doneEvent));
   converter_model u_converter_model (.ref_clk(ref_clk), .slow(slow), .convReq(convReq),
      .convRsp(convRsp));

   //////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      if (errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regBus <= '{1'b1, a, d};
      @(posedge ref_clk);
      regBus.wrEn <= 1'b0;
   endtask : wr
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      regBus.addr <= a;
      @(posedge ref_clk);
      #1 v = rdData;
      chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, v});
   endtask : rdChk
   task automatic pollCtrl(input logic [7:0] exp);
      for (int i = 0; i < 60 && v !== exp; i++) begin
         @(posedge ref_clk);
         regBus.addr <= 8'h15;
         @(posedge ref_clk);
         #1 v = rdData;
      end
      chk("control", {8'h00, exp}, {8'h00, v});
      if (v !== exp) end_of_test();
   endtask : pollCtrl

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdChk(8'h15, 8'h30);
      for (int a = 8'h16; a <= 8'h1b; a++) rdChk(a[7:0], 8'h00);
      wr(8'h15, 8'h0f);
      rdChk(8'h15, 8'h00);
      wr(8'h16, 8'hff);
      rdChk(8'h16, 8'hfd);
      wr(8'h17, 8'haa);
      rdChk(8'h17, 8'h00);
      for (int r = 0; r < 4; r++) begin
         wr(8'h15, {2'b00, r[1:0], 4'h0});
         @(posedge ref_clk);
         #1 chk("resolution", {14'h0000, r[1:0]}, {14'h0000, convReq.resolution});
      end
      chk("starts while off", 16'h0000, 16'(chans.size()));
      // One shot over two channels
      wr(8'h16, 8'h3f);
      wr(8'h15, 8'hc0);
      pollCtrl(8'h40);
      chk("events", 16'h0001, 16'(evCnt));
      chk("pass length", 16'h0002, 16'(chans.size()));
      rdChk(8'h17, 8'h8a);
      rdChk(8'h18, 8'h5b);
      rdChk(8'h19, 8'h0a);
      rdChk(8'h1a, 8'h5a);
      // Masked slow pass over every channel
      slow = 1'b1;
      chans.delete();
      evCnt = 0;
      wr(8'h16, 8'h02);
      doneMask <= 1'b1;
      wr(8'h15, 8'hc0);
      pollCtrl(8'h40);
      chk("masked events", 16'h0000, 16'(evCnt));
      chk("pass length", 16'h0007, 16'(chans.size()));
      foreach (order[i]) chk("channel", {13'h0000, order[i]}, {13'h0000, chans[i]});
      // Continuous, then watchdog and register reset
      slow = 1'b0;
      wr(8'h16, 8'h7f);
      chans.delete();
      wr(8'h15, 8'ha0);
      for (int i = 0; i < 400 && chans.size() < 3; i++) @(posedge ref_clk);
      if (chans.size() < 3) begin
         chk("repeat count", 16'h0003, 16'(chans.size()));
         end_of_test();
      end
      chk("repeat", {13'h0000, 3'h7}, {13'h0000, chans[2]});
      watchdogExpire <= 1'b1;
      @(posedge ref_clk);
      watchdogExpire <= 1'b0;
      rdChk(8'h15, 8'h20);
      rdChk(8'h17, 8'h8a);
      regReset <= 1'b1;
      @(posedge ref_clk);
      regReset <= 1'b0;
      rdChk(8'h17, 8'h00);
      rdChk(8'h15, 8'h30);
      end_of_test();
   end
endmodule : monitor_adc_control_bench
